// >>> verilog/fsp_flash_protect.sv
// flash option, configuration and protection register logic with backdoor key compare
// assumes nv bytes are stable from reset release; key bytes of flash arrive on a flat port
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ns
`include "fsp_regs.svh"
module fsp_flash_protect
    import fsp_pkg::*;
#(
    parameter int KEY_BYTES = 8,
    parameter int ADDR_W = 16
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // nonvolatile bytes from flash
    input wire logic [7:0] nv_options_byte,
    input wire logic [7:0] nv_protection_byte,
    input wire logic [8*KEY_BYTES-1:0] backdoor_key_bytes,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_from_debug,
    output logic [7:0] reg_rdata,
    // cpu writes into flash space
    input wire logic cpu_wr,
    input wire logic [ADDR_W-1:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_from_debug,
    // command launch from the sequencer
    input wire logic cmd_launch,
    input wire logic cmd_is_modify,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic blank_check_pass,
    // results
    output logic cmd_start,
    output logic cmd_accept,
    output logic protection_violation_flag,
    output logic secure,
    output logic debug_mem_block,
    output logic vector_redirect_disable
);
    logic [7:0] options_shadow_reg;
    logic [7:0] protection_shadow_reg;
    logic [7:0] flash_config_reg;
    logic [1:0] security_code_reg;
    logic [7:0] key_wr_mask_reg;
    logic key_ok_reg;
    logic [3:0] cmp_idx_reg;
    logic cmp_busy_reg;
    logic [2:0] rd_idx;
    logic [7:0] key_rd_data;
    fsp_load_e load_reg;
    logic key_window;
    logic key_write;
    logic in_protected;
    logic backdoor_enable_clear;
    logic [ADDR_W-1:0] boundary;

    //============================================================
    // nonvolatile copy at reset release
    // a strap-like copy: async reset takes constants, the load follows release
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            load_reg <= FSP_LOAD_IDLE;
        end else begin
            case (load_reg)
                FSP_LOAD_IDLE: load_reg <= FSP_LOAD_COPY;
                FSP_LOAD_COPY: load_reg <= FSP_LOAD_DONE;
                FSP_LOAD_DONE: load_reg <= FSP_LOAD_DONE;
                default: load_reg <= FSP_LOAD_IDLE;
            endcase
        end
    end

    // options shadow: only a reset reloads it, software writes fall on the floor
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            options_shadow_reg <= 8'h00;
        end else if (load_reg == FSP_LOAD_IDLE) begin
            options_shadow_reg <= nv_options_byte & `FSP_OPT_MASK; // R1 R2 R3
        end
    end

    // protection shadow: debug may rewrite it, firmware may not
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            protection_shadow_reg <= 8'hFF;
        end else if (load_reg == FSP_LOAD_IDLE) begin
            protection_shadow_reg <= nv_protection_byte; // R14
        end else if (reg_wr && reg_addr == `FSP_OFS_PROTECT && reg_from_debug) begin
            protection_shadow_reg <= reg_wdata; // R15
        end
    end

    //============================================================
    // configuration register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flash_config_reg <= `FSP_CFG_RESET; // R21
        end else if (reg_wr && reg_addr == `FSP_OFS_CONFIG) begin
            flash_config_reg <= reg_wdata & `FSP_CFG_MASK; // R11
        end
    end

    assign backdoor_enable_clear = reg_wr && reg_addr == `FSP_OFS_CONFIG
        && flash_config_reg[`FSP_CFG_KEYWEN] && !reg_wdata[`FSP_CFG_KEYWEN];

    //============================================================
    // key window decode
    assign key_window = cpu_addr[ADDR_W-1:3] == `FSP_KEY_BASE >> 3;
    // debug writes never count as key bytes
    assign key_write = cpu_wr && key_window && flash_config_reg[`FSP_CFG_KEYWEN]
        && !cpu_from_debug; // R13 R6

    // with key enable clear a write anywhere starts a command
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmd_start <= 1'b0;
        end else begin
            cmd_start <= cpu_wr && !flash_config_reg[`FSP_CFG_KEYWEN]; // R12
        end
    end

    // track which key bytes arrived, each at its own offset to keep order
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            key_wr_mask_reg <= 8'h00;
        end else if (backdoor_enable_clear) begin
            key_wr_mask_reg <= 8'h00;
        end else if (key_write) begin
            key_wr_mask_reg[cpu_addr[2:0]] <= 1'b1; // R5
        end
    end

    fsp_key_store #(
        .DEPTH(KEY_BYTES),
        .AW(3)
    ) u_keys (
        .clock(clock),
        .rst_n(rst_n),
        .wr_en(key_write),
        .wr_addr(cpu_addr[2:0]),
        .wr_data(cpu_wdata),
        .rd_addr(rd_idx),
        .rd_data(key_rd_data)
    );

    assign rd_idx = cmp_idx_reg[2:0];

    //============================================================
    // compare sequence after key enable is cleared, one byte per cycle
    // the store read is registered, so the check trails the index by a cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmp_busy_reg <= 1'b0;
            cmp_idx_reg <= 4'h0;
            key_ok_reg <= 1'b0;
        end else if (backdoor_enable_clear) begin
            cmp_busy_reg <= options_shadow_reg[`FSP_OPT_BACKDOOR] && (&key_wr_mask_reg); // R4 R19
            cmp_idx_reg <= 4'h0;
            key_ok_reg <= 1'b1;
        end else if (cmp_busy_reg) begin
            cmp_idx_reg <= cmp_idx_reg + 4'h1;
            if (cmp_idx_reg != 4'h0 &&
                key_rd_data != backdoor_key_bytes[8*(cmp_idx_reg-4'h1) +: 8]) begin
                key_ok_reg <= 1'b0; // R5
            end
            if (cmp_idx_reg == {1'b0, `FSP_KEY_LAST} + 4'h1) begin
                cmp_busy_reg <= 1'b0;
            end
        end
    end

    //============================================================
    // effective security code
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            security_code_reg <= 2'h0;
        end else if (load_reg == FSP_LOAD_IDLE) begin
            security_code_reg <= nv_options_byte[1:0];
        end else if (blank_check_pass) begin
            security_code_reg <= `FSP_SEC_UNSECURED; // R10
        end else if (cmp_busy_reg && cmp_idx_reg == {1'b0, `FSP_KEY_LAST} + 4'h1
            && key_ok_reg && key_rd_data == backdoor_key_bytes[8*`FSP_KEY_LAST +: 8]) begin
            security_code_reg <= `FSP_SEC_UNSECURED; // R5 R10
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            secure <= 1'b1;
            debug_mem_block <= 1'b1;
            vector_redirect_disable <= 1'b0;
        end else begin
            secure <= security_code_reg != `FSP_SEC_UNSECURED; // R8
            debug_mem_block <= security_code_reg != `FSP_SEC_UNSECURED; // R9
            vector_redirect_disable <= options_shadow_reg[`FSP_OPT_NOREDIR]; // R7
        end
    end

    //============================================================
    // block protection: locations above boundary are protected
    // select field bits 7..1 form the upper address bits of the last unprotected 512-byte block
    assign boundary = ADDR_W'({protection_shadow_reg[7:1], 9'h1FF});
    assign in_protected = !protection_shadow_reg[`FSP_PROT_DIS] && cmd_addr > boundary; // R16 R18

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmd_accept <= 1'b0;
        end else begin
            cmd_accept <= cmd_launch && !(cmd_is_modify && in_protected); // R17 R20
        end
    end

    // sticky violation, set wins over a write-one clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            protection_violation_flag <= 1'b0;
        end else if (cmd_launch && cmd_is_modify && in_protected) begin
            protection_violation_flag <= 1'b1; // R20
        end else if (reg_wr && reg_addr == `FSP_OFS_VIOL_CLR && reg_wdata[0]) begin
            protection_violation_flag <= 1'b0;
        end
    end

    //============================================================
    // register read, data one cycle after the strobe
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `FSP_RD_ZERO;
        end else if (reg_rd) begin
            case (reg_addr)
                `FSP_OFS_OPTIONS: reg_rdata <= options_shadow_reg; // R2
                `FSP_OFS_CONFIG: reg_rdata <= flash_config_reg; // R11
                `FSP_OFS_PROTECT: reg_rdata <= protection_shadow_reg;
                `FSP_OFS_STATUS: reg_rdata <= {5'h00, vector_redirect_disable,
                    protection_violation_flag, secure};
                default: reg_rdata <= `FSP_RD_ZERO;
            endcase
        end else begin
            reg_rdata <= `FSP_RD_ZERO;
        end
    end
endmodule

// >>> include/fsp_regs.svh
// register offsets, field positions and reset values for the flash protection block
// assumes a plain register port with byte-wide data and a 16-bit cpu address for the key window
//
//============================================================
// What this block does
// [R1] reset copies options byte into options shadow
// [R2] options bits 5..2 read zero; writes ignored
// [R3] options change needs reprogram plus new reset
// [R4] backdoor disabled when option bit 7 zero
// [R5] matching ordered 8-byte key unsecures until reset
// [R6] debug-sourced key writes are refused
// [R7] option bit 6 one disables vector redirection
// [R8] only security code 1:0 means unsecured
// [R9] secure state blocks unsecured memory access
// [R10] key match or blank check sets 1:0
// [R11] config bits 7..5 rw; 4..0 read zero
// [R12] key enable zero: key window starts commands
// [R13] key enable one: key window takes key bytes
// [R14] reset copies protection byte into protection shadow
// [R15] protection writes only accepted from debug
// [R16] protect select sets unprotected high boundary
// [R17] no erase or program inside protected block
// [R18] protection disable bit 0 protects nothing
// [R19] clearing key enable triggers key compare
// [R20] protected command ignored, violation flag set
// [R21] key enable resets to zero
`ifndef FSP_REGS_SVH
`define FSP_REGS_SVH

//============================================================
// register map (byte offsets on the local port)
`define FSP_OFS_OPTIONS 4'h0
`define FSP_OFS_CONFIG 4'h1
`define FSP_OFS_PROTECT 4'h2
`define FSP_OFS_STATUS 4'h3
`define FSP_OFS_VIOL_CLR 4'h4

//============================================================
// field positions
`define FSP_OPT_BACKDOOR 7
`define FSP_OPT_NOREDIR 6
`define FSP_OPT_MASK 8'hC3
`define FSP_CFG_KEYWEN 5
`define FSP_CFG_MASK 8'hE0
`define FSP_PROT_DIS 0
`define FSP_STAT_SECURE 0
`define FSP_STAT_VIOL 1
`define FSP_STAT_REDIR 2

//============================================================
// values
`define FSP_SEC_UNSECURED 2'h2
`define FSP_CFG_RESET 8'h00
`define FSP_KEY_BASE 16'hFFB0
`define FSP_KEY_LAST 3'h7
`define FSP_RD_ZERO 8'h00
`define FSP_PROT_SHIFT 9

`endif

// >>> include/fsp_pkg.sv
// types shared by the flash protection block
// assumes nothing beyond a SystemVerilog compiler
package fsp_pkg;
    typedef enum logic [1:0] {
        FSP_LOAD_IDLE,
        FSP_LOAD_COPY,
        FSP_LOAD_DONE
    } fsp_load_e;
    typedef logic [7:0] fsp_byte_t;
endpackage

// >>> verilog/fsp_key_store.sv
// small register file holding the eight backdoor key bytes written by firmware
// assumes writes and reads are synchronous to clock; read data is registered
`timescale 1ns/1ns
module fsp_key_store
    import fsp_pkg::*;
#(
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // write side
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    // read side
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem_reg [DEPTH];

    //============================================================
    // storage, one generate entry per byte
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_byte
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    mem_reg[gi] <= 8'h00;
                end else if (wr_en && wr_addr == AW'(gi)) begin
                    mem_reg[gi] <= wr_data;
                end
            end
        end
    endgenerate

    // registered read port
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= mem_reg[rd_addr];
        end
    end
endmodule

// >>> sim/fsp_flash_protect_props.sv
// checker for the flash protection block, top-level ports only
// assumes one clock domain with an async active-low reset
`timescale 1ns/1ns
`include "fsp_regs.svh"
module fsp_flash_protect_props (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // flash space and commands
    input wire logic cpu_wr,
    input wire logic cmd_launch,
    input wire logic cmd_is_modify,
    // results
    input wire logic cmd_start,
    input wire logic cmd_accept,
    input wire logic protection_violation_flag,
    input wire logic secure,
    input wire logic debug_mem_block
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    //============================================================
    // named steps
    sequence s_opt_rd;
        reg_rd && reg_addr == `FSP_OFS_OPTIONS;
    endsequence
    sequence s_cfg_rd;
        reg_rd && reg_addr == `FSP_OFS_CONFIG;
    endsequence
    // a fresh modify launch: flag low, so its rise is this launch's doing
    sequence s_fresh_modify;
        cmd_launch && cmd_is_modify && !protection_violation_flag;
    endsequence
    //============================================================
    // properties
    chk_opt_unused: assert property (s_opt_rd |=> reg_rdata[5:2] == 4'h0)
        else $error("options unused bits not zero");
    chk_cfg_unused: assert property (s_cfg_rd |=> reg_rdata[4:0] == 5'h00)
        else $error("config low bits not zero");
    chk_start_cause: assert property (!cpu_wr |=> !cmd_start)
        else $error("command start without flash write");
    chk_accept_cause: assert property (!cmd_launch |=> !cmd_accept)
        else $error("accept without launch");
    chk_launch_result: assert property (cmd_launch |=> cmd_accept || protection_violation_flag)
        else $error("launch neither accepted nor flagged");
    chk_modify_excl: assert property (s_fresh_modify |=> cmd_accept != protection_violation_flag)
        else $error("modify both accepted and flagged");
    chk_viol_hold: assert property (protection_violation_flag
        && !(reg_wr && reg_addr == `FSP_OFS_VIOL_CLR) |=> protection_violation_flag)
        else $error("violation flag dropped without clear");
    chk_debug_block: assert property (debug_mem_block == secure)
        else $error("debug block differs from secure");
    chk_secure_sticky: assert property (!secure |=> !secure)
        else $error("security re-engaged without reset");
endmodule

bind fsp_flash_protect fsp_flash_protect_props i_props (.*);

// >>> sim/tb_fsp_flash_protect.sv
// self-checking bench for the flash protection block
// assumes read data one cycle after the strobe, outputs registered
`timescale 1ns/1ns
`include "fsp_regs.svh"
module tb_fsp_flash_protect
    import fsp_pkg::*;
;
    // stored key, arbitrary test pattern
    localparam logic [63:0] KEY = 64'h8E1D_44F2_09B7_C3A5;
    logic clock = 1'b0, rst_n = 1'b0;
    logic [7:0] nv_options_byte = 8'h00, nv_protection_byte = 8'hFF;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, cpu_wdata = 8'h00;
    logic reg_wr = 1'b0, reg_rd = 1'b0, reg_from_debug = 1'b0, cpu_wr = 1'b0;
    logic cpu_from_debug = 1'b0, cmd_launch = 1'b0, cmd_is_modify = 1'b0;
    logic blank_check_pass = 1'b0;
    logic [15:0] cpu_addr = 16'h0000, cmd_addr = 16'h0000;
    logic [7:0] reg_rdata;
    logic cmd_start, cmd_accept, protection_violation_flag, secure;
    logic debug_mem_block, vector_redirect_disable;
    int num_errors = 0, cmp_count = 0;

    fsp_flash_protect i_dut (.clock(clock), .rst_n(rst_n), .nv_options_byte(nv_options_byte),
        .nv_protection_byte(nv_protection_byte), .backdoor_key_bytes(KEY),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_from_debug(reg_from_debug), .reg_rdata(reg_rdata), .cpu_wr(cpu_wr),
        .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_from_debug(cpu_from_debug),
        .cmd_launch(cmd_launch), .cmd_is_modify(cmd_is_modify), .cmd_addr(cmd_addr),
        .blank_check_pass(blank_check_pass), .cmd_start(cmd_start), .cmd_accept(cmd_accept),
        .protection_violation_flag(protection_violation_flag), .secure(secure),
        .debug_mem_block(debug_mem_block), .vector_redirect_disable(vector_redirect_disable));

    // 25 MHz bus clock
    always #20 clock = ~clock;

    //============================================================
    // shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask
    task automatic stop_test;
        if (num_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // reset held two cycles, then three edges before any request
    task automatic reset_dut(input logic [7:0] opt, input logic [7:0] prot);
        @(posedge clock);
        rst_n <= 1'b0;
        nv_options_byte <= opt;
        nv_protection_byte <= prot;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [7:0] d, input logic dbg);
        @(posedge clock);
        {reg_wr, reg_addr, reg_wdata, reg_from_debug} <= {1'b1, a, d, dbg};
        @(posedge clock);
        {reg_wr, reg_from_debug} <= 2'b00;
    endtask
    task automatic reg_check(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clock);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic cpu_write(input logic [15:0] a, input logic [7:0] d, input logic dbg,
        input logic exp_start);
        @(posedge clock);
        {cpu_wr, cpu_addr, cpu_wdata, cpu_from_debug} <= {1'b1, a, d, dbg};
        @(posedge clock);
        {cpu_wr, cpu_from_debug} <= 2'b00;
        #1 chk(cmd_start, exp_start);
    endtask
    task automatic launch(input logic [15:0] a, input logic modify, input logic acc,
        input logic viol);
        @(posedge clock);
        {cmd_launch, cmd_addr, cmd_is_modify} <= {1'b1, a, modify};
        @(posedge clock);
        cmd_launch <= 1'b0;
        #1 chk({cmd_accept, protection_violation_flag}, {acc, viol});
    endtask

    //============================================================
    // scenarios
    task automatic t_reset_load;
        logic [7:0] nv;
        logic [1:0] cc;
        for (int c = 0; c < 4; c++) begin
            cc = c[1:0];
            nv = {cc[0], cc[1], 4'hF, cc};
            reset_dut(nv, {cc, 6'h15});
            reg_check(`FSP_OFS_OPTIONS, nv & `FSP_OPT_MASK);
            reg_write(`FSP_OFS_OPTIONS, ~nv, 1'b0);
            reg_check(`FSP_OFS_OPTIONS, nv & `FSP_OPT_MASK);
            reg_check(`FSP_OFS_PROTECT, {cc, 6'h15});
            reg_check(`FSP_OFS_CONFIG, 8'h00);
            reg_check(`FSP_OFS_STATUS, {5'h00, nv[6], 1'b0, cc != 2'h2});
            chk(vector_redirect_disable, nv[6]);
        end
    endtask
    task automatic t_regs_rw;
        reset_dut(8'h02, 8'h5A);
        reg_write(`FSP_OFS_CONFIG, 8'hFF, 1'b0);
        reg_check(`FSP_OFS_CONFIG, 8'hE0);
        reg_check(4'hF, 8'h00);
        cpu_write(16'hFFB3, 8'h11, 1'b0, 1'b0);
        reg_write(`FSP_OFS_CONFIG, 8'h00, 1'b0);
        cpu_write(16'hFFB3, 8'h11, 1'b0, 1'b1);
        reg_write(`FSP_OFS_PROTECT, 8'h00, 1'b0);
        reg_check(`FSP_OFS_PROTECT, 8'h5A);
        reg_write(`FSP_OFS_PROTECT, 8'h3C, 1'b1);
        reg_check(`FSP_OFS_PROTECT, 8'h3C);
    endtask
    task automatic t_backdoor(input logic en, input logic dbg, input logic rev,
        input logic exp_sec);
        reset_dut({en, 7'h00}, 8'hFF);
        reg_write(`FSP_OFS_CONFIG, 8'h20, 1'b0);
        for (int i = 0; i < 8; i++)
            cpu_write(`FSP_KEY_BASE + 16'(i), KEY[8*(rev ? 7-i : i) +: 8], dbg, 1'b0);
        reg_write(`FSP_OFS_CONFIG, 8'h00, 1'b0);
        repeat (30) @(posedge clock);
        #1 chk(secure, exp_sec);
        chk(debug_mem_block, exp_sec);
    endtask
    task automatic t_blank_check;
        reset_dut(8'h80, 8'hFF);
        @(posedge clock);
        blank_check_pass <= 1'b1;
        @(posedge clock);
        blank_check_pass <= 1'b0;
        repeat (30) @(posedge clock);
        #1 chk(secure, 1'b0);
    endtask
    // boundary {7'h78, 9'h1FF} = F1FF: F200 is the lowest protected byte
    task automatic t_protect_cmd;
        reset_dut(8'h02, 8'hF0);
        launch(16'hF200, 1'b1, 1'b0, 1'b1);
        // a fresh violation in the same cycle as the clear must keep the flag up
        @(posedge clock);
        {cmd_launch, cmd_addr, cmd_is_modify} <= {1'b1, 16'hF200, 1'b1};
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, `FSP_OFS_VIOL_CLR, 8'h01};
        @(posedge clock);
        {cmd_launch, reg_wr} <= 2'b00;
        #1 chk(protection_violation_flag, 1'b1);
        reg_write(`FSP_OFS_VIOL_CLR, 8'h01, 1'b0);
        reg_check(`FSP_OFS_STATUS, 8'h00);
        launch(16'hF1FF, 1'b1, 1'b1, 1'b0);
        launch(16'hF200, 1'b0, 1'b1, 1'b0);
        reg_write(`FSP_OFS_PROTECT, 8'hF1, 1'b1);
        launch(16'hF200, 1'b1, 1'b1, 1'b0);
    endtask

    // hang guard
    initial begin
        #2000000;
        num_errors++;
        stop_test();
    end
    initial begin
        t_reset_load();
        t_regs_rw();
        t_backdoor(1'b1, 1'b0, 1'b0, 1'b0);
        t_backdoor(1'b0, 1'b0, 1'b0, 1'b1);
        t_backdoor(1'b1, 1'b1, 1'b0, 1'b1);
        t_backdoor(1'b1, 1'b0, 1'b1, 1'b1);
        t_blank_check();
        t_protect_cmd();
        stop_test();
    end
endmodule
